// *** olsd_pkg.sv ***
/*
 * Shared constants and types for the eight-channel low-side switch serial port:
 * register map, status bit layout, protection timing.
 * Assumes a 25 MHz system clock; the package itself holds no logic.
 */
`default_nettype none
package olsd_pkg;
    localparam int unsigned CH_NUM          = 8;
    localparam int unsigned AXI_AW          = 5;

    // register byte addresses
    localparam logic [4:0]  ADDR_IRQ_STATUS = 5'h00;
    localparam logic [4:0]  ADDR_IRQ_CLEAR  = 5'h04;
    localparam logic [4:0]  ADDR_IRQ_ENABLE = 5'h08;
    localparam logic [4:0]  ADDR_CONTROL    = 5'h0C;
    localparam logic [4:0]  ADDR_LATCH      = 5'h10;
    localparam logic [4:0]  ADDR_SENSE      = 5'h14;

    // status bit positions
    localparam int unsigned IRQ_FRAME_DONE  = 0;
    localparam int unsigned IRQ_FAULT_CLR   = 1;
    localparam int unsigned IRQ_FRAME_ODD   = 2;
    localparam int unsigned IRQ_NUM         = 3;

    localparam int unsigned CTRL_PROT_EN    = 0;
    localparam logic [0:0]  CTRL_RESET      = 1'h1;

    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // fault clear delay window after select rises
    localparam int unsigned CLK_PERIOD_NS   = 40;
    localparam int unsigned FAULT_MIN_NS    = 75000;
    localparam int unsigned FAULT_MAX_NS    = 250000;
    localparam int unsigned FAULT_MIN_CYC   = (FAULT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned FAULT_MAX_CYC   = FAULT_MAX_NS / CLK_PERIOD_NS;
    localparam int unsigned FAULT_CNT_W     = 13;

    localparam int unsigned BIT_CNT_W       = 3;

    // serial pins as seen by the block, after synchronisation
    typedef struct packed {
        logic select_n;
        logic shift_clock;
        logic serial_in;
    } olsd_pins_s;
endpackage : olsd_pkg
`default_nettype wire

// *** olsd_port.sv ***
/*
 * Serial control and diagnostic port of an eight-channel low-side switch,
 * with an AXI4-Lite register slave and a level interrupt.
 * Assumes the serial pins and the output sense bits are asynchronous to aclk
 * and that the serial clock runs far slower than aclk (edges are found by sampling).
 */
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
// Behaviour
// - reset clears shift register, latch and outputs
// - select rising copies inverted shift register to latch
// - select falling loads sense bits into shifter
// - serial_out driven only while select is low
// - sense bit one when pin voltage high
// - command bit one means channel off
// - shift clock rising presents next bit
// - shift clock falling samples serial_in
// - channel seven first, channel zero last
// - fault clears latch 75 to 250 us
// - on channel with high pin is faulted
// - any bit count passes through for chaining
// - first rising edge shows channel seven sense
`default_nettype none
module olsd_port
    import olsd_pkg::*;
#(
    parameter int unsigned FAULT_MAX_CYCLES = FAULT_MAX_CYC  // latest fault clear, in aclk cycles
) (
    input  wire logic                    aclk,          // system clock, 25 MHz
    input  wire logic                    aresetn,       // synchronous reset, active low
    input  wire logic [AXI_AW-1:0]       s_awaddr,      // write address
    input  wire logic [2:0]              s_awprot,      // unused protection bits
    input  wire logic                    s_awvalid,     // write address valid
    output var  logic                    s_awready,     // write address ready
    input  wire logic [31:0]             s_wdata,       // write data
    input  wire logic [3:0]              s_wstrb,       // write byte strobes
    input  wire logic                    s_wvalid,      // write data valid
    output var  logic                    s_wready,      // write data ready
    output var  logic [1:0]              s_bresp,       // write response
    output var  logic                    s_bvalid,      // write response valid
    input  wire logic                    s_bready,      // write response ready
    input  wire logic [AXI_AW-1:0]       s_araddr,      // read address
    input  wire logic [2:0]              s_arprot,      // unused protection bits
    input  wire logic                    s_arvalid,     // read address valid
    output var  logic                    s_arready,     // read address ready
    output var  logic [31:0]             s_rdata,       // read data
    output var  logic [1:0]              s_rresp,       // read response
    output var  logic                    s_rvalid,      // read data valid
    input  wire logic                    s_rready,      // read data ready
    input  wire logic                    select_n,      // serial select pin, active low
    input  wire logic                    shift_clock,   // serial clock pin
    input  wire logic                    serial_in,     // serial data pin in
    output var  logic                    serial_out,    // serial data pin out
    output var  logic                    serial_out_oe_n, // serial out enable, low while driving
    input  wire logic [CH_NUM-1:0]       out_sense,     // 1 while output pin is above threshold
    output var  logic [CH_NUM-1:0]       drive_on,      // 1 turns channel stage on
    output var  logic                    irq            // level interrupt, active high
);
    import olsd_pkg::*;

    // pin synchronisers: stage one feeds stage two only
    olsd_pins_s        pin_s1_reg, pin_s2_reg, pin_s3_reg;
    olsd_pins_s        pin_s1_next, pin_s2_next, pin_s3_next;
    logic [CH_NUM-1:0] sense_s1_reg, sense_s2_reg;
    logic [CH_NUM-1:0] sense_s1_next, sense_s2_next;

    always_comb begin
        pin_s1_next   = '{select_n: select_n, shift_clock: shift_clock, serial_in: serial_in};
        pin_s2_next   = pin_s1_reg;
        pin_s3_next   = pin_s2_reg;
        sense_s1_next = out_sense;
        sense_s2_next = sense_s1_reg;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1_reg   <= '{select_n: 1'b1, shift_clock: 1'b0, serial_in: 1'b0};
            pin_s2_reg   <= '{select_n: 1'b1, shift_clock: 1'b0, serial_in: 1'b0};
            pin_s3_reg   <= '{select_n: 1'b1, shift_clock: 1'b0, serial_in: 1'b0};
            sense_s1_reg <= '0;
            sense_s2_reg <= '0;
        end else begin
            pin_s1_reg   <= pin_s1_next;
            pin_s2_reg   <= pin_s2_next;
            pin_s3_reg   <= pin_s3_next;
            sense_s1_reg <= sense_s1_next;
            sense_s2_reg <= sense_s2_next;
        end
    end

    logic sel_fall, sel_rise, sclk_rise, sclk_fall, selected;
    assign selected  = !pin_s2_reg.select_n;
    assign sel_fall  = pin_s3_reg.select_n && !pin_s2_reg.select_n;
    assign sel_rise  = !pin_s3_reg.select_n && pin_s2_reg.select_n;
    assign sclk_rise = !pin_s3_reg.shift_clock && pin_s2_reg.shift_clock;
    assign sclk_fall = pin_s3_reg.shift_clock && !pin_s2_reg.shift_clock;

    // serial shifter, latch and fault timer
    logic [CH_NUM-1:0]      shreg_reg, shreg_next;
    logic [CH_NUM-1:0]      latch_reg, latch_next;
    logic [CH_NUM-1:0]      drive_reg, drive_next;
    logic                   sdo_reg, sdo_next;
    logic                   sdo_oe_n_reg, sdo_oe_n_next;
    logic [BIT_CNT_W-1:0]   bits_reg, bits_next;
    logic [FAULT_CNT_W-1:0] since_reg, since_next;
    logic                   prot_en_reg;
    logic                   fault_armed;
    logic [CH_NUM-1:0]      fault_hit;
    logic                   ev_done, ev_fault, ev_odd;

    // the window opens at the least delay; with the pin still high the channel clears at once
    assign fault_armed = since_reg >= FAULT_CNT_W'(FAULT_MIN_CYC);
    assign fault_hit   = (prot_en_reg && fault_armed && !sel_rise) ? (latch_reg & sense_s2_reg) : '0;
    assign ev_done     = sel_rise;
    assign ev_fault    = |fault_hit;
    assign ev_odd      = sel_rise && (bits_reg != '0);

    always_comb begin
        shreg_next    = shreg_reg;
        latch_next    = latch_reg & ~fault_hit;
        sdo_next      = sdo_reg;
        sdo_oe_n_next = !selected;
        bits_next     = bits_reg;
        since_next    = since_reg;
        if (since_reg < FAULT_CNT_W'(FAULT_MAX_CYCLES)) begin
            since_next = since_reg + FAULT_CNT_W'(1);
        end
        if (sel_fall) begin
            shreg_next = sense_s2_reg;
            bits_next  = '0;
        end else if (selected && sclk_rise) begin
            sdo_next = shreg_reg[CH_NUM-1];
        end else if (selected && sclk_fall) begin
            shreg_next = {shreg_reg[CH_NUM-2:0], pin_s2_reg.serial_in};
            bits_next  = bits_reg + BIT_CNT_W'(1);
        end
        if (sel_rise) begin
            latch_next = ~shreg_reg;
            since_next = '0;
        end
        drive_next = latch_next;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shreg_reg    <= '0;
            latch_reg    <= '0;
            drive_reg    <= '0;
            sdo_reg      <= 1'b0;
            sdo_oe_n_reg <= 1'b1;
            bits_reg     <= '0;
            since_reg    <= '0;
        end else begin
            shreg_reg    <= shreg_next;
            latch_reg    <= latch_next;
            drive_reg    <= drive_next;
            sdo_reg      <= sdo_next;
            sdo_oe_n_reg <= sdo_oe_n_next;
            bits_reg     <= bits_next;
            since_reg    <= since_next;
        end
    end

    assign serial_out      = sdo_reg;
    assign serial_out_oe_n = sdo_oe_n_reg;
    assign drive_on        = drive_reg;

    // register slave: address and data may arrive in either order
    logic              aw_rdy_reg, aw_rdy_next, w_rdy_reg, w_rdy_next;
    logic              bvalid_reg, bvalid_next, ar_rdy_reg, ar_rdy_next;
    logic              rvalid_reg, rvalid_next;
    logic [1:0]        bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [31:0]       rdata_reg, rdata_next, wdata_reg, wdata_next;
    logic [3:0]        wstrb_reg, wstrb_next;
    logic [AXI_AW-1:0] awaddr_reg, awaddr_next;
    logic [IRQ_NUM-1:0] status_reg, status_next, enable_reg, enable_next;
    logic              prot_en_next, irq_reg, irq_next;
    logic              do_write;
    logic [IRQ_NUM-1:0] clr_bits, ev_bits;

    assign do_write = !aw_rdy_reg && !w_rdy_reg && !bvalid_reg;
    assign ev_bits  = {ev_odd, ev_fault, ev_done};

    always_comb begin
        aw_rdy_next  = aw_rdy_reg;
        w_rdy_next   = w_rdy_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        ar_rdy_next  = ar_rdy_reg;
        rvalid_next  = rvalid_reg;
        rresp_next   = rresp_reg;
        rdata_next   = rdata_reg;
        awaddr_next  = awaddr_reg;
        wdata_next   = wdata_reg;
        wstrb_next   = wstrb_reg;
        enable_next  = enable_reg;
        prot_en_next = prot_en_reg;
        clr_bits     = '0;
        if (s_awvalid && aw_rdy_reg) begin
            aw_rdy_next = 1'b0;
            awaddr_next = s_awaddr;
        end
        if (s_wvalid && w_rdy_reg) begin
            w_rdy_next = 1'b0;
            wdata_next = s_wdata;
            wstrb_next = s_wstrb;
        end
        if (do_write) begin
            bvalid_next = 1'b1;
            bresp_next  = RESP_OKAY;
            unique case (awaddr_reg)
                ADDR_IRQ_CLEAR:  if (wstrb_reg[0]) clr_bits = wdata_reg[IRQ_NUM-1:0];
                ADDR_IRQ_ENABLE: if (wstrb_reg[0]) enable_next = wdata_reg[IRQ_NUM-1:0];
                ADDR_CONTROL:    if (wstrb_reg[0]) prot_en_next = wdata_reg[CTRL_PROT_EN];
                ADDR_IRQ_STATUS, ADDR_LATCH, ADDR_SENSE: bresp_next = RESP_OKAY;
                default:         bresp_next = RESP_SLVERR;
            endcase
        end
        if (bvalid_reg && s_bready) begin
            bvalid_next = 1'b0;
            aw_rdy_next = 1'b1;
            w_rdy_next  = 1'b1;
        end
        if (s_arvalid && ar_rdy_reg) begin
            ar_rdy_next = 1'b0;
            rvalid_next = 1'b1;
            rresp_next  = RESP_OKAY;
            rdata_next  = '0;
            unique case (s_araddr)
                ADDR_IRQ_STATUS: rdata_next[IRQ_NUM-1:0] = status_reg;
                ADDR_IRQ_CLEAR:  rdata_next = '0;
                ADDR_IRQ_ENABLE: rdata_next[IRQ_NUM-1:0] = enable_reg;
                ADDR_CONTROL:    rdata_next[CTRL_PROT_EN] = prot_en_reg;
                ADDR_LATCH:      rdata_next[CH_NUM-1:0] = latch_reg;
                ADDR_SENSE:      rdata_next[CH_NUM-1:0] = sense_s2_reg;
                default:         rresp_next = RESP_SLVERR;
            endcase
        end
        if (rvalid_reg && s_rready) begin
            rvalid_next = 1'b0;
            ar_rdy_next = 1'b1;
        end
        // a new event outlives a clear written in the same cycle
        status_next = (status_reg & ~clr_bits) | ev_bits;
        irq_next    = |(status_next & enable_next);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_rdy_reg  <= 1'b1;
            w_rdy_reg   <= 1'b1;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
            ar_rdy_reg  <= 1'b1;
            rvalid_reg  <= 1'b0;
            rresp_reg   <= RESP_OKAY;
            rdata_reg   <= '0;
            awaddr_reg  <= '0;
            wdata_reg   <= '0;
            wstrb_reg   <= '0;
            status_reg  <= '0;
            enable_reg  <= '0;
            prot_en_reg <= CTRL_RESET[0];
            irq_reg     <= 1'b0;
        end else begin
            aw_rdy_reg  <= aw_rdy_next;
            w_rdy_reg   <= w_rdy_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            ar_rdy_reg  <= ar_rdy_next;
            rvalid_reg  <= rvalid_next;
            rresp_reg   <= rresp_next;
            rdata_reg   <= rdata_next;
            awaddr_reg  <= awaddr_next;
            wdata_reg   <= wdata_next;
            wstrb_reg   <= wstrb_next;
            status_reg  <= status_next;
            enable_reg  <= enable_next;
            prot_en_reg <= prot_en_next;
            irq_reg     <= irq_next;
        end
    end

    assign s_awready = aw_rdy_reg;
    assign s_wready  = w_rdy_reg;
    assign s_bvalid  = bvalid_reg;
    assign s_bresp   = bresp_reg;
    assign s_arready = ar_rdy_reg;
    assign s_rvalid  = rvalid_reg;
    assign s_rresp   = rresp_reg;
    assign s_rdata   = rdata_reg;
    assign irq       = irq_reg;

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_reset_clears_all: assert property (@(posedge aclk) disable iff (1'b0)
        !aresetn |=> (latch_reg == '0) && (drive_on == '0) && (shreg_reg == '0) && serial_out_oe_n)
        else $error("reset did not clear latch, outputs and shifter");
    a_latch_on_rise: assert property (sel_rise |=> latch_reg == ~$past(shreg_reg) && drive_on == latch_reg)
        else $error("latch did not take inverted shifter on select rise");
    a_sense_on_fall: assert property (sel_fall |=> shreg_reg == $past(sense_s2_reg))
        else $error("shifter did not load sense bits on select fall");
    a_sdo_enable: assert property ($changed(pin_s2_reg.select_n) |=> serial_out_oe_n == $past(pin_s2_reg.select_n))
        else $error("serial out enable does not follow select");
    a_sdo_present: assert property (selected && sclk_rise && !sel_fall |=> serial_out == $past(shreg_reg[CH_NUM-1]))
        else $error("serial out did not show top shifter bit");
    a_shift_sample: assert property (selected && sclk_fall && !sel_fall
        |=> shreg_reg == {$past(shreg_reg[CH_NUM-2:0]), $past(pin_s2_reg.serial_in)})
        else $error("shifter did not take serial in on falling clock");
    a_fault_not_early: assert property (sel_rise |=> !fault_armed [*8])
        else $error("fault clear armed too soon after select rise");
    a_fault_window: assert property (since_reg == FAULT_CNT_W'(FAULT_MAX_CYCLES) |-> fault_armed)
        else $error("fault clear not armed by the latest delay");
    a_fault_clears: assert property (prot_en_reg && fault_armed && !sel_rise && |(latch_reg & sense_s2_reg)
        |=> (latch_reg & $past(sense_s2_reg)) == '0)
        else $error("faulted channel left on");
    a_irq_level: assert property (|(status_reg & enable_reg) |-> ##[0:1] irq)
        else $error("interrupt missing with enabled status set");
endmodule : olsd_port
`default_nettype wire

// *** olsd_spi_master.sv ***
/*
 * Behavioural serial bus master that stands in front of the switch port.
 * Assumes the bench calls transfer() from one process at a time and that aclk runs at 25 MHz.
 */
`default_nettype none
module olsd_spi_master (
    input  wire logic aclk,            // bench clock, paces the serial clock
    output var  logic select_n,        // select, active low
    output var  logic shift_clock,     // serial clock, stands low outside frames
    output var  logic serial_in,       // command bits to the port
    input  wire logic serial_out,      // diagnostic bits from the port
    input  wire logic serial_out_oe_n  // port output enable, low while driving
);
    timeunit 1ns;
    timeprecision 1ps;

    // undriven line floats, so a late enable is read as z and never matches
    wire logic so_wire = serial_out_oe_n ? 1'bz : serial_out;

    initial begin
        select_n    = 1'b1;
        shift_clock = 1'b0;
        serial_in   = 1'b0;
    end

    // half period of four aclk cycles gives a 320 ns serial clock
    task automatic transfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
        rx = '0;
        @(posedge aclk);
        select_n <= 1'b0;
        repeat (8) @(posedge aclk);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge aclk);
            if (i < n - 1) rx = {rx[30:0], so_wire};
            shift_clock <= 1'b1;
            serial_in   <= tx[i];
            repeat (4) @(posedge aclk);
            shift_clock <= 1'b0;
            repeat (3) @(posedge aclk);
        end
        @(posedge aclk);
        rx = {rx[30:0], so_wire};
        // released data line: show the inverse rather than a stale bit
        serial_in <= ~serial_in;
        repeat (7) @(posedge aclk);
        select_n <= 1'b1;
    endtask : transfer
endmodule : olsd_spi_master
`default_nettype wire

// *** testbench.sv ***
/*
 * Self-checking bench for the switch port: registers, interrupt, serial frames,
 * chaining and overload clearing.
 * Assumes olsd_pkg, olsd_port and olsd_spi_master are compiled first.
 */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import olsd_pkg::*;

    localparam int FMAX = 2000;  // shortened latest fault clear, in cycles

    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [4:0]  s_awaddr = '0, s_araddr = '0;
    logic [2:0]  s_awprot = '0, s_arprot = '0;
    logic [31:0] s_wdata = '0;
    logic [3:0]  s_wstrb = 4'hF;
    logic        s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
    logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq;
    logic        select_n, shift_clock, serial_in, serial_out, serial_out_oe_n;
    logic [1:0]  s_bresp, s_rresp;
    logic [31:0] s_rdata, rx;
    logic [7:0]  out_sense = 8'hFF, short_mask = 8'h00, drive_on;
    int          miscompares = 0, comparisons = 0;

    always #20 aclk = ~aclk;

    // an off channel is pulled high by its load; a shorted one reads high always
    always @(posedge aclk) out_sense <= ~drive_on | short_mask;

    olsd_port #(.FAULT_MAX_CYCLES(FMAX)) olsd_port_i (.aclk, .aresetn, .s_awaddr, .s_awprot, .s_awvalid,
        .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
        .s_arprot, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .select_n,
        .shift_clock, .serial_in, .serial_out, .serial_out_oe_n, .out_sense, .drive_on, .irq);

    olsd_spi_master olsd_spi_master_i (.aclk, .select_n, .shift_clock, .serial_in, .serial_out,
        .serial_out_oe_n);

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic close_out();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic timed_out();
        miscompares++;
        $display("ERROR at %0t ns: got %h expected %h", $time, 1'b0, 1'b1);
        close_out();
    endtask : timed_out

    task automatic axi_write(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_awaddr  <= a;
        s_wdata   <= d;
        s_awvalid <= 1'b1;
        s_wvalid  <= 1'b1;
        s_bready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
            if (s_bvalid) break;
        end
        if (n == 50) timed_out();
        s_bready <= 1'b0;
        check(32'(s_bresp), 32'(er));
    endtask : axi_write

    task automatic rd_chk(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_araddr  <= a;
        s_arvalid <= 1'b1;
        s_rready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_arready) s_arvalid <= 1'b0;
            if (s_rvalid) break;
        end
        if (n == 50) timed_out();
        s_rready <= 1'b0;
        check(s_rdata, ed);
        check(32'(s_rresp), 32'(er));
    endtask : rd_chk

    task automatic frame(input logic [31:0] tx, input int n, input logic [31:0] ex);
        olsd_spi_master_i.transfer(tx, n, rx);
        check(rx, ex);
        repeat (8) @(posedge aclk);
    endtask : frame

    task automatic t_reset_regs();
        check(32'(drive_on), 32'h0);
        check(32'(serial_out_oe_n), 32'h1);
        rd_chk(ADDR_IRQ_STATUS, 32'h0, RESP_OKAY);
        // a write with lane zero masked must leave the enable untouched
        s_wstrb <= 4'h0;
        axi_write(ADDR_IRQ_ENABLE, 32'h7, RESP_OKAY);
        s_wstrb <= 4'hF;
        rd_chk(ADDR_IRQ_ENABLE, 32'h0, RESP_OKAY);
        rd_chk(ADDR_IRQ_CLEAR, 32'h0, RESP_OKAY);
        rd_chk(ADDR_CONTROL, 32'h1, RESP_OKAY);
        axi_write(ADDR_LATCH, 32'hFF, RESP_OKAY);
        rd_chk(ADDR_LATCH, 32'h0, RESP_OKAY);
        rd_chk(5'h18, 32'h0, RESP_SLVERR);
        axi_write(5'h1C, 32'hFF, RESP_SLVERR);
    endtask : t_reset_regs

    task automatic t_frames();
        frame(32'h0E, 8, 32'hFF);
        check(32'(drive_on), 32'hF1);
        check(32'(serial_out_oe_n), 32'h1);
        frame(32'hC8, 8, 32'h0E);
        check(32'(drive_on), 32'h37);
        rd_chk(ADDR_LATCH, 32'h37, RESP_OKAY);
        rd_chk(ADDR_SENSE, 32'hC8, RESP_OKAY);
        rd_chk(ADDR_IRQ_STATUS, 32'h1, RESP_OKAY);
    endtask : t_frames

    task automatic t_chain();
        axi_write(ADDR_IRQ_CLEAR, 32'h7, RESP_OKAY);
        frame(32'hB461, 16, 32'hC8B4);
        check(32'(drive_on), 32'h9E);
        frame(32'hA3C, 12, 32'h61A);
        check(32'(drive_on), 32'hC3);
        rd_chk(ADDR_IRQ_STATUS, 32'h5, RESP_OKAY);
    endtask : t_chain

    task automatic t_irq();
        axi_write(ADDR_IRQ_CLEAR, 32'h7, RESP_OKAY);
        axi_write(ADDR_IRQ_ENABLE, 32'h1, RESP_OKAY);
        rd_chk(ADDR_IRQ_ENABLE, 32'h1, RESP_OKAY);
        check(32'(irq), 32'h0);
        frame(32'hFF, 8, 32'h3C);
        check(32'(irq), 32'h1);
        axi_write(ADDR_IRQ_CLEAR, 32'h1, RESP_OKAY);
        repeat (2) @(posedge aclk);
        check(32'(irq), 32'h0);
        axi_write(ADDR_IRQ_ENABLE, 32'h0, RESP_OKAY);
        frame(32'hFF, 8, 32'hFF);
        check(32'(irq), 32'h0);
        rd_chk(ADDR_IRQ_STATUS, 32'h1, RESP_OKAY);
    endtask : t_irq

    task automatic t_fault();
        int n;
        axi_write(ADDR_IRQ_CLEAR, 32'h7, RESP_OKAY);
        short_mask <= 8'h01;
        olsd_spi_master_i.transfer(32'hFE, 8, rx);
        repeat (8) @(posedge aclk);
        check(32'(drive_on), 32'h01);
        for (n = 8; n < FMAX + 50; n++) begin
            @(posedge aclk);
            if (drive_on[0] === 1'b0) break;
        end
        check(32'(n >= FAULT_MIN_CYC && n <= FMAX + 8), 32'h1);
        check(32'(drive_on), 32'h00);
        rd_chk(ADDR_IRQ_STATUS, 32'h3, RESP_OKAY);
        // with protection off the shorted channel must stay on
        axi_write(ADDR_CONTROL, 32'h0, RESP_OKAY);
        olsd_spi_master_i.transfer(32'hFE, 8, rx);
        repeat (FMAX + 50) @(posedge aclk);
        check(32'(drive_on), 32'h01);
    endtask : t_fault

    task automatic t_reset_mid();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        short_mask <= 8'h00;
        @(posedge aclk);
        check(32'(drive_on), 32'h0);
        rd_chk(ADDR_CONTROL, 32'h1, RESP_OKAY);
        rd_chk(ADDR_IRQ_STATUS, 32'h0, RESP_OKAY);
        frame(32'h5F, 8, 32'hFF);
        check(32'(drive_on), 32'hA0);
    endtask : t_reset_mid

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset_regs();
        t_frames();
        t_chain();
        t_irq();
        t_fault();
        t_reset_mid();
        close_out();
    end
endmodule : testbench
`default_nettype wire
